// ===== dv/camac_discriminator_control_tb.sv
// Self-checking bench for the discriminator dataway control
`timescale 1ns/1ps
`default_nettype none
module camac_discriminator_control_tb;
    logic         mclk = 1'b0;
    logic         resetn, veto_in, test_in, front_local_setting;
    logic         station_sel, dw_strobe1, dw_strobe2, dw_clear, dw_init, dw_inhibit;
    logic         x_resp, q_resp, hit_or, local_led, stored_thr_en;
    logic [4:0]   func;
    logic [3:0]   subaddr;
    logic [15:0]  over_thr, write_data, read_data, chan_out;
    logic [127:0] thr_level, thr_exp;
    int           n_errors = 0;
    int           n_tests = 0;
    int           n_cyc = 0;
    int           n_all = 0;
    int           k0;

    always #5 mclk = ~mclk;

    camac_discriminator_control dut (.mclk(mclk), .resetn(resetn), .station_sel(station_sel), .func(func),
        .subaddr(subaddr), .write_data(write_data), .dw_strobe1(dw_strobe1), .dw_strobe2(dw_strobe2),
        .dw_clear(dw_clear), .dw_init(dw_init), .dw_inhibit(dw_inhibit), .veto_in(veto_in),
        .test_in(test_in), .front_local_setting(front_local_setting), .over_thr(over_thr),
        .read_data(read_data), .x_resp(x_resp), .q_resp(q_resp), .chan_out(chan_out), .hit_or(hit_or),
        .local_led(local_led), .stored_thr_en(stored_thr_en), .thr_level(thr_level));

    dataway_ctl_model ctl (.mclk(mclk), .station_sel(station_sel), .func(func), .subaddr(subaddr),
        .write_data(write_data), .dw_strobe1(dw_strobe1), .dw_strobe2(dw_strobe2), .dw_clear(dw_clear),
        .dw_init(dw_init), .dw_inhibit(dw_inhibit), .read_data(read_data), .x_resp(x_resp),
        .q_resp(q_resp));

    // Counts all-channel pulses; the self-test lasts only one cycle
    always @(posedge mclk) begin
        n_cyc <= n_cyc + 1;
        if (chan_out === 16'hffff) n_all <= n_all + 1;
        if (n_cyc == 6000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic op(input logic [4:0] f, input logic [3:0] a, input logic [15:0] w,
                      input logic [15:0] er, input logic ex, input logic eq, input logic cr);
        logic [15:0] r;
        logic        x, q;
        ctl.cycle(f, a, w, r, x, q);
        if (cr) chk("read_data", 128'(r), 128'(er));
        chk("x_resp", 128'(x), 128'(ex));
        chk("q_resp", 128'(q), 128'(eq));
    endtask : op

    // Waits a bounded time for a hit, then compares the channel pattern
    task automatic fire(input logic [15:0] exp);
        int k;
        for (k = 0; k < 8 && hit_or !== 1'b1; k++) @(negedge mclk);
        chk("chan_out", 128'(chan_out), 128'(exp));
        chk("hit_or", 128'(hit_or), 128'(|exp));
    endtask : fire

    task automatic trig(input logic [15:0] exp);
        @(posedge mclk) test_in <= 1'b1;
        fire(exp);
        @(posedge mclk) test_in <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : trig

    task automatic pulse_thr(input logic [15:0] v);
        @(posedge mclk) over_thr <= v;
        repeat (4) @(posedge mclk);
        over_thr <= 16'h0000;
        repeat (4) @(posedge mclk);
    endtask : pulse_thr

    function automatic logic [7:0] tv(input int i);
        return 8'(i * 17);
    endfunction : tv

    initial begin
        resetn = 1'b0;
        veto_in = 1'b0;
        test_in = 1'b0;
        front_local_setting = 1'b0;
        over_thr = 16'h0000;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        // Power-on mask and thresholds are all ones, and module reset is still issued first
        op(camac_disc_pkg::FN_RESET, 4'h0, 16'h0, 16'h0, 1'b1, 1'b1, 1'b0);
        op(camac_disc_pkg::FN_READ_MASK, 4'h0, 16'h0, 16'hffff, 1'b1, 1'b1, 1'b1);
        for (k0 = 0; k0 < 16; k0++) begin
            op(camac_disc_pkg::FN_WRITE_THR, 4'(k0), {8'ha5, tv(k0)}, 16'h0, 1'b1, 1'b1, 1'b0);
            thr_exp[8*k0 +: 8] = tv(k0);
        end
        @(negedge mclk) chk("thr_level", thr_level, thr_exp);
        for (k0 = 15; k0 >= 0; k0--)
            op(camac_disc_pkg::FN_READ_THR, 4'(k0), 16'h0, {8'hff, tv(k0)}, 1'b1, 1'b1, 1'b1);
        op(camac_disc_pkg::FN_WRITE_MASK, 4'h0, 16'h000c, 16'h0, 1'b1, 1'b1, 1'b0);
        op(camac_disc_pkg::FN_READ_MASK, 4'h0, 16'h0, 16'h000c, 1'b1, 1'b1, 1'b1);
        op(5'h03, 4'h0, 16'h0, 16'h0000, 1'b0, 1'b0, 1'b1);
        // Comparator path blocked, test input still fires the mask
        ctl.inh(1'b1);
        @(posedge mclk) over_thr <= 16'h0005;
        repeat (6) @(negedge mclk) chk("chan_out", 128'(chan_out), 128'h0);
        trig(16'h000c);
        // Veto rises before inhibit falls, so no gap lets the comparator through
        @(posedge mclk) veto_in <= 1'b1;
        ctl.inh(1'b0);
        repeat (6) @(negedge mclk) chk("chan_out", 128'(chan_out), 128'h0);
        trig(16'h000c);
        @(posedge mclk) veto_in <= 1'b0;
        fire(16'h0004);
        @(posedge mclk) over_thr <= 16'h0000;
        pulse_thr(16'h0004);
        op(camac_disc_pkg::FN_TEST_ACT, 4'h0, 16'h0, 16'h0, 1'b1, 1'b1, 1'b0);
        op(camac_disc_pkg::FN_TEST_ACT, 4'h0, 16'h0, 16'h0, 1'b1, 1'b0, 1'b0);
        pulse_thr(16'h0001);
        op(camac_disc_pkg::FN_TEST_ACT, 4'h0, 16'h0, 16'h0, 1'b1, 1'b0, 1'b0);
        // Self-test ignores both blocking inputs
        ctl.inh(1'b1);
        @(posedge mclk) veto_in <= 1'b1;
        k0 = n_all;
        op(camac_disc_pkg::FN_COMMON_TEST, 4'h0, 16'h0, 16'h0, 1'b1, 1'b1, 1'b0);
        chk("self_test", 128'(n_all > k0), 128'h1);
        ctl.inh(1'b0);
        @(posedge mclk) veto_in <= 1'b0;
        pulse_thr(16'h0004);
        op(camac_disc_pkg::FN_RESET, 4'h0, 16'h0, 16'h0, 1'b1, 1'b1, 1'b0);
        op(camac_disc_pkg::FN_READ_MASK, 4'h0, 16'h0, 16'hffff, 1'b1, 1'b1, 1'b1);
        op(camac_disc_pkg::FN_TEST_ACT, 4'h0, 16'h0, 16'h0, 1'b1, 1'b0, 1'b0);
        op(camac_disc_pkg::FN_READ_THR, 4'h5, 16'h0, {8'hff, tv(5)}, 1'b1, 1'b1, 1'b1);
        for (k0 = 0; k0 < 2; k0++) begin
            op(camac_disc_pkg::FN_WRITE_MASK, 4'h0, 16'h000c, 16'h0, 1'b1, 1'b1, 1'b0);
            pulse_thr(16'h0008);
            ctl.zc(k0[0]);
            op(camac_disc_pkg::FN_READ_MASK, 4'h0, 16'h0, 16'hffff, 1'b1, 1'b1, 1'b1);
            op(camac_disc_pkg::FN_TEST_ACT, 4'h0, 16'h0, 16'h0, 1'b1, 1'b0, 1'b0);
        end
        op(camac_disc_pkg::FN_WRITE_MASK, 4'h0, 16'h000c, 16'h0, 1'b1, 1'b1, 1'b0);
        @(posedge mclk) front_local_setting <= 1'b1;
        repeat (3) @(negedge mclk);
        chk("local_led", 128'(local_led), 128'h1);
        chk("stored_thr_en", 128'(stored_thr_en), 128'h0);
        chk("thr_level", thr_level, {128{1'b1}});
        op(camac_disc_pkg::FN_READ_THR, 4'h3, 16'h0, 16'hffff, 1'b1, 1'b1, 1'b1);
        op(camac_disc_pkg::FN_READ_MASK, 4'h0, 16'h0, 16'hffff, 1'b1, 1'b1, 1'b1);
        op(camac_disc_pkg::FN_WRITE_MASK, 4'h0, 16'h0001, 16'h0, 1'b1, 1'b0, 1'b0);
        trig(16'hffff);
        // Module reset by function is ignored in local, so the latch survives
        pulse_thr(16'h0001);
        op(camac_disc_pkg::FN_RESET, 4'h0, 16'h0, 16'h0, 1'b1, 1'b0, 1'b0);
        op(camac_disc_pkg::FN_TEST_ACT, 4'h0, 16'h0, 16'h0, 1'b1, 1'b1, 1'b0);
        @(posedge mclk) front_local_setting <= 1'b0;
        repeat (3) @(negedge mclk);
        chk("local_led", 128'(local_led), 128'h0);
        chk("stored_thr_en", 128'(stored_thr_en), 128'h1);
        op(camac_disc_pkg::FN_READ_THR, 4'h3, 16'h0, 16'hffff, 1'b1, 1'b1, 1'b1);
        op(camac_disc_pkg::FN_READ_MASK, 4'h0, 16'h0, 16'hffff, 1'b1, 1'b1, 1'b1);
        final_report();
    end
endmodule : camac_discriminator_control_tb
`default_nettype wire

// ===== dv/dataway_ctl_model.sv
// Crate controller model that runs dataway cycles for one station
`timescale 1ns/1ps
`default_nettype none
module dataway_ctl_model (
    input  wire logic        mclk,
    output logic             station_sel,
    output logic [4:0]       func,
    output logic [3:0]       subaddr,
    output logic [15:0]      write_data,
    output logic             dw_strobe1,
    output logic             dw_strobe2,
    output logic             dw_clear,
    output logic             dw_init,
    output logic             dw_inhibit,
    input  wire logic [15:0] read_data,
    input  wire logic        x_resp,
    input  wire logic        q_resp
);
    initial begin
        station_sel = 1'b0;
        func        = 5'h1f;
        subaddr     = 4'hf;
        write_data  = 16'h0000;
        dw_strobe1  = 1'b0;
        dw_strobe2  = 1'b0;
        dw_clear    = 1'b0;
        dw_init     = 1'b0;
        dw_inhibit  = 1'b0;
    end

    // N held over S1 and S2; answer taken mid-cycle, before S1 can change state
    task automatic cycle(input logic [4:0] f, input logic [3:0] a, input logic [15:0] w,
                         output logic [15:0] r, output logic x, output logic q);
        @(posedge mclk);
        station_sel <= 1'b1;
        func        <= f;
        subaddr     <= a;
        @(posedge mclk);
        @(negedge mclk);
        r = read_data;
        x = x_resp;
        q = q_resp;
        @(posedge mclk);
        dw_strobe1 <= 1'b1;
        write_data <= w;
        repeat (2) @(posedge mclk);
        dw_strobe1 <= 1'b0;
        dw_strobe2 <= 1'b1;
        @(posedge mclk);
        dw_strobe2 <= 1'b0;
        @(posedge mclk);
        // Released lines show garbage, not the old value
        station_sel <= 1'b0;
        func        <= ~f;
        subaddr     <= ~a;
        write_data  <= ~w;
        @(posedge mclk);
    endtask : cycle

    // Unaddressed clear (c=1) or initialise (c=0), qualified by S2
    task automatic zc(input logic c);
        @(posedge mclk);
        dw_clear <= c;
        dw_init  <= ~c;
        @(posedge mclk);
        dw_strobe2 <= 1'b1;
        @(posedge mclk);
        dw_strobe2 <= 1'b0;
        dw_clear   <= 1'b0;
        dw_init    <= 1'b0;
    endtask : zc

    task automatic inh(input logic v);
        @(posedge mclk);
        dw_inhibit <= v;
    endtask : inh
endmodule : dataway_ctl_model
`default_nettype wire

// ===== pkg/camac_disc_pkg.sv
// Shared constants and types for the dataway control of the discriminator
// Overview of operation
// - Clear, initialise or function 9 set all mask bits and clear activity latch.
// - Module reset never alters any of the sixteen stored thresholds.
// - Function 17 loads the sixteen mask bits from write data; one enables.
// - Function 1 returns the whole enable mask on the read lines.
// - Dataway inhibit blocks channel outputs but never test or function 25 pulses.
// - Each channel keeps its own eight bit threshold, two millivolt steps.
// - Function 16 stores low write byte into the subaddressed channel threshold.
// - Function 0 returns subaddressed threshold low, upper read byte all ones.
// - In local mode threshold and mask reads work and return all ones.
// - Test input pulse fires every enabled channel together.
// - Function 25 fires all channel outputs together as self test.
// - External block input suppresses channels, but not test or function 25.
// - Unmasked over-threshold sets sticky activity; function 2 reports and clears it.
// - Answer X for every valid function addressed to the station.
// - Q only in remote, except reads 0 and 1; function 2 gives latch.
// - Entering local mode forces mask and thresholds to ones; stored thresholds unused.
// - Going local to remote keeps the all-ones contents until rewritten.
// - Mode follows the front-panel switch; local indicator lit in local.
// - Combined hit output is the OR of all channel outputs.
// - Local mode ignores dataway writes and functions 9 and 25; mask reads as all enabled.
package camac_disc_pkg;
    localparam int          NUM_CH      = 16;
    localparam int          THR_W       = 8;
    localparam int          DW_W        = 16;
    localparam int          SUB_W       = 4;
    localparam int          FN_W        = 5;
    localparam int          SYNC_STAGES = 2;
    localparam int          THR_STEP_UV = -2000;

    localparam logic [4:0]  FN_READ_THR    = 5'h00;
    localparam logic [4:0]  FN_READ_MASK   = 5'h01;
    localparam logic [4:0]  FN_TEST_ACT    = 5'h02;
    localparam logic [4:0]  FN_RESET       = 5'h09;
    localparam logic [4:0]  FN_WRITE_THR   = 5'h10;
    localparam logic [4:0]  FN_WRITE_MASK  = 5'h11;
    localparam logic [4:0]  FN_COMMON_TEST = 5'h19;

    localparam logic [15:0] MASK_ALL_ON  = 16'hffff;
    localparam logic [15:0] CHAN_NONE    = 16'h0000;
    localparam logic [7:0]  THR_ALL_ONES = 8'hff;
    localparam logic [7:0]  READ_FILL    = 8'hff;
    localparam logic [15:0] READ_ALL_ON  = 16'hffff;
    localparam logic [15:0] READ_IDLE    = 16'h0000;

    typedef enum logic [1:0] {
        CYC_IDLE    = 2'b00,
        CYC_ADDR    = 2'b01,
        CYC_STROBED = 2'b11,
        CYC_DONE    = 2'b10
    } cycle_state_t;
endpackage : camac_disc_pkg

// ===== verilog/camac_discriminator_control.sv
// Dataway control, mask, thresholds and channel gating of the discriminator
`timescale 1ns/1ps
`default_nettype none
module camac_discriminator_control (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic         station_sel,
    input  wire logic [4:0]   func,
    input  wire logic [3:0]   subaddr,
    input  wire logic [15:0]  write_data,
    input  wire logic         dw_strobe1,
    input  wire logic         dw_strobe2,
    input  wire logic         dw_clear,
    input  wire logic         dw_init,
    input  wire logic         dw_inhibit,
    input  wire logic         veto_in,
    input  wire logic         test_in,
    input  wire logic         front_local_setting,
    input  wire logic [15:0]  over_thr,
    output logic [15:0]       read_data,
    output logic              x_resp,
    output logic              q_resp,
    output logic [15:0]       chan_out,
    output logic              hit_or,
    output logic              local_led,
    output logic              stored_thr_en,
    output logic [127:0]      thr_level
);
    typedef struct packed {
        camac_disc_pkg::cycle_state_t st;
        logic [15:0]                  mask;
        logic [15:0][7:0]             thr;
        logic                         act;
        logic                         local_mode;
        logic                         use_stored;
        logic [15:0]                  rdata;
        logic                         x;
        logic                         q;
        logic [15:0]                  chan;
        logic                         hit;
        logic                         s1_d;
        logic                         s2_d;
        logic                         test_d;
    } ctrl_state_t;

    ctrl_state_t state_ff;
    ctrl_state_t nxt_state;

    logic [15:0] ovr_level;
    logic [15:0] ovr_rise;
    logic        dec_valid;
    logic        dec_rd_thr;
    logic        dec_rd_mask;
    logic        dec_test_act;
    logic        dec_reset;
    logic        dec_wr_thr;
    logic        dec_wr_mask;
    logic        dec_common_test;

    logic        s1_rise;
    logic        s2_rise;
    logic        test_rise;
    logic        strobe_act;
    logic        reset_evt;
    logic        act_clear;
    logic        any_hit;
    logic        blocked;
    logic        f25_fire;
    logic        remote_ctl;
    logic [15:0] eff_mask;

    genvar ch;
    generate
        for (ch = 0; ch < camac_disc_pkg::NUM_CH; ch++) begin : g_sync
            comparator_sync #(
                .STAGES (camac_disc_pkg::SYNC_STAGES)
            ) u_sync (
                .mclk     (mclk),
                .resetn   (resetn),
                .async_in (over_thr[ch]),
                .level    (ovr_level[ch]),
                .rise     (ovr_rise[ch])
            );
        end
    endgenerate

    camac_func_decode u_dec (
        .func        (func),
        .valid       (dec_valid),
        .rd_thr      (dec_rd_thr),
        .rd_mask     (dec_rd_mask),
        .test_act    (dec_test_act),
        .mod_reset   (dec_reset),
        .wr_thr      (dec_wr_thr),
        .wr_mask     (dec_wr_mask),
        .common_test (dec_common_test)
    );

    assign s1_rise    = dw_strobe1 & ~state_ff.s1_d;
    assign s2_rise    = dw_strobe2 & ~state_ff.s2_d;
    assign test_rise  = test_in & ~state_ff.test_d;
    // Actions happen once per dataway cycle, at the first strobe
    assign strobe_act = (state_ff.st == camac_disc_pkg::CYC_ADDR) & station_sel & s1_rise;
    assign remote_ctl = strobe_act & ~state_ff.local_mode;
    assign reset_evt  = (s2_rise & (dw_clear | dw_init)) | (remote_ctl & dec_reset);
    assign act_clear  = strobe_act & dec_test_act;
    assign f25_fire   = remote_ctl & dec_common_test;
    assign eff_mask   = state_ff.local_mode ? camac_disc_pkg::MASK_ALL_ON : state_ff.mask;
    assign any_hit    = |(ovr_rise & eff_mask);
    assign blocked    = dw_inhibit | veto_in;

    always_comb begin
        nxt_state            = state_ff;
        nxt_state.s1_d       = dw_strobe1;
        nxt_state.s2_d       = dw_strobe2;
        nxt_state.test_d     = test_in;
        nxt_state.local_mode = front_local_setting;
        nxt_state.use_stored = ~front_local_setting;

        // Dataway cycle sequencing; read data and answers frozen for the cycle
        unique case (state_ff.st)
            camac_disc_pkg::CYC_IDLE: begin
                if (station_sel) begin
                    nxt_state.st = camac_disc_pkg::CYC_ADDR;
                    nxt_state.x  = dec_valid;
                    nxt_state.q  = 1'b0;
                    if (dec_test_act) begin
                        nxt_state.q = state_ff.act;
                    end else if (dec_rd_thr | dec_rd_mask) begin
                        nxt_state.q = 1'b1;
                    end else if (dec_valid) begin
                        nxt_state.q = ~state_ff.local_mode;
                    end
                    if (state_ff.local_mode && (dec_rd_thr || dec_rd_mask)) begin
                        nxt_state.rdata = camac_disc_pkg::READ_ALL_ON;
                    end else if (dec_rd_thr) begin
                        nxt_state.rdata = {camac_disc_pkg::READ_FILL, state_ff.thr[subaddr]};
                    end else if (dec_rd_mask) begin
                        nxt_state.rdata = state_ff.mask;
                    end else begin
                        nxt_state.rdata = camac_disc_pkg::READ_IDLE;
                    end
                end
            end
            camac_disc_pkg::CYC_ADDR: begin
                if (!station_sel) begin
                    nxt_state.st = camac_disc_pkg::CYC_IDLE;
                end else if (s1_rise) begin
                    nxt_state.st = camac_disc_pkg::CYC_STROBED;
                end
            end
            camac_disc_pkg::CYC_STROBED: begin
                if (!station_sel) begin
                    nxt_state.st = camac_disc_pkg::CYC_IDLE;
                end else if (s2_rise) begin
                    nxt_state.st = camac_disc_pkg::CYC_DONE;
                end
            end
            camac_disc_pkg::CYC_DONE: begin
                if (!station_sel) begin
                    nxt_state.st = camac_disc_pkg::CYC_IDLE;
                end
            end
        endcase
        if (nxt_state.st == camac_disc_pkg::CYC_IDLE) begin
            nxt_state.x     = 1'b0;
            nxt_state.q     = 1'b0;
            nxt_state.rdata = camac_disc_pkg::READ_IDLE;
        end

        // Register writes; thresholds are not touched by module reset
        if (remote_ctl && dec_wr_mask) begin
            nxt_state.mask = write_data;
        end
        if (remote_ctl && dec_wr_thr) begin
            nxt_state.thr[subaddr] = write_data[7:0];
        end
        if (reset_evt) begin
            nxt_state.mask = camac_disc_pkg::MASK_ALL_ON;
        end
        // Forced every cycle in local, so the ones remain on return to remote
        if (state_ff.local_mode) begin
            nxt_state.mask = camac_disc_pkg::MASK_ALL_ON;
            nxt_state.thr  = {camac_disc_pkg::NUM_CH{camac_disc_pkg::THR_ALL_ONES}};
        end

        // Sticky activity: a hit in the clearing cycle survives
        if (act_clear || reset_evt) begin
            nxt_state.act = 1'b0;
        end
        if (any_hit) begin
            nxt_state.act = 1'b1;
        end

        // Test pulses bypass inhibit and block, so they are ORed after gating
        nxt_state.chan = (blocked ? camac_disc_pkg::CHAN_NONE : (ovr_level & eff_mask))
                       | (test_rise ? eff_mask : camac_disc_pkg::CHAN_NONE)
                       | (f25_fire ? camac_disc_pkg::MASK_ALL_ON : camac_disc_pkg::CHAN_NONE);
        nxt_state.hit  = |nxt_state.chan;
    end

    // Power-up mask and thresholds are all ones so a remote start is defined until programmed
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_ff.st         <= camac_disc_pkg::CYC_IDLE;
            state_ff.mask       <= camac_disc_pkg::MASK_ALL_ON;
            state_ff.thr        <= {camac_disc_pkg::NUM_CH{camac_disc_pkg::THR_ALL_ONES}};
            state_ff.act        <= 1'b0;
            state_ff.local_mode <= 1'b0;
            state_ff.use_stored <= 1'b0;
            state_ff.rdata      <= camac_disc_pkg::READ_IDLE;
            state_ff.x          <= 1'b0;
            state_ff.q          <= 1'b0;
            state_ff.chan       <= camac_disc_pkg::CHAN_NONE;
            state_ff.hit        <= 1'b0;
            state_ff.s1_d       <= 1'b0;
            state_ff.s2_d       <= 1'b0;
            state_ff.test_d     <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign read_data     = state_ff.rdata;
    assign x_resp        = state_ff.x;
    assign q_resp        = state_ff.q;
    assign chan_out      = state_ff.chan;
    assign hit_or        = state_ff.hit;
    assign local_led     = state_ff.local_mode;
    assign stored_thr_en = state_ff.use_stored;
    assign thr_level     = state_ff.thr;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // A hit in the reset cycle sets the latch again, so it is left out here
    a_reset_mask_set: assert property ((reset_evt && !any_hit)
                                       |=> (state_ff.mask == 16'hffff) && !state_ff.act)
        else $error("Module reset did not enable all channels or clear activity");
    a_reset_keeps_thr: assert property ((reset_evt && !state_ff.local_mode && !(remote_ctl && dec_wr_thr))
                                        |=> $stable(thr_level))
        else $error("Module reset changed a threshold");
    a_mask_write_load: assert property ((remote_ctl && dec_wr_mask && !reset_evt)
                                        |=> state_ff.mask == $past(write_data))
        else $error("Mask write not loaded");
    a_mask_read_back: assert property ((state_ff.st == camac_disc_pkg::CYC_IDLE && station_sel
                                        && dec_rd_mask && !state_ff.local_mode) |=> read_data == $past(state_ff.mask))
        else $error("Mask read returned wrong data");
    a_thr_read_fill: assert property ((state_ff.st == camac_disc_pkg::CYC_IDLE && station_sel
                                       && dec_rd_thr) |=> read_data[15:8] == 8'hff)
        else $error("Threshold read upper byte not all ones");
    a_thr_write_store: assert property ((remote_ctl && dec_wr_thr)
                                        |=> thr_level[$past(subaddr)*8 +: 8] == $past(write_data[7:0]))
        else $error("Threshold write not stored");
    a_local_read_ones: assert property ((state_ff.st == camac_disc_pkg::CYC_IDLE && station_sel
                                         && state_ff.local_mode && (dec_rd_thr || dec_rd_mask))
                                        |=> read_data == 16'hffff && q_resp)
        else $error("Local read not all ones with Q");
    a_inhibit_blocks_out: assert property ((blocked && !test_rise && !f25_fire) |=> chan_out == 16'h0000)
        else $error("Channel output while inhibited or blocked");
    a_test_fires_enabled: assert property (test_rise |=> (chan_out & $past(eff_mask)) == $past(eff_mask))
        else $error("Test pulse missed an enabled channel");
    a_f25_fires_all: assert property (f25_fire |=> chan_out == 16'hffff)
        else $error("Common test did not fire all channels");
    a_act_set_wins: assert property (any_hit |=> state_ff.act [*1]
                                     ##1 (state_ff.act || $past(act_clear || reset_evt)))
        else $error("Activity latch lost a hit");
    a_x_for_valid: assert property ((state_ff.st == camac_disc_pkg::CYC_IDLE && station_sel)
                                    |=> x_resp == $past(dec_valid))
        else $error("X answer does not match function validity");
    a_local_forces_ones: assert property (local_led |=> state_ff.mask == 16'hffff
                                          && stored_thr_en == !$past(front_local_setting)
                                          && thr_level == {128{1'b1}})
        else $error("Local mode did not force mask and thresholds to ones");
    a_or_of_channels: assert property (hit_or == (|chan_out))
        else $error("Hit output differs from OR of channels");

    c_mask_write: cover property (remote_ctl && dec_wr_mask);
    c_activity_read: cover property (state_ff.act ##[1:50] act_clear);
    c_test_under_veto: cover property (test_rise && blocked);
    c_local_to_remote: cover property (local_led ##1 !local_led);
endmodule : camac_discriminator_control
`default_nettype wire

// ===== verilog/camac_func_decode.sv
// Dataway function decoder for the discriminator station
`timescale 1ns/1ps
`default_nettype none
module camac_func_decode (
    input  wire logic [4:0] func,
    output logic            valid,
    output logic            rd_thr,
    output logic            rd_mask,
    output logic            test_act,
    output logic            mod_reset,
    output logic            wr_thr,
    output logic            wr_mask,
    output logic            common_test
);
    assign rd_thr      = (func == camac_disc_pkg::FN_READ_THR);
    assign rd_mask     = (func == camac_disc_pkg::FN_READ_MASK);
    assign test_act    = (func == camac_disc_pkg::FN_TEST_ACT);
    assign mod_reset   = (func == camac_disc_pkg::FN_RESET);
    assign wr_thr      = (func == camac_disc_pkg::FN_WRITE_THR);
    assign wr_mask     = (func == camac_disc_pkg::FN_WRITE_MASK);
    assign common_test = (func == camac_disc_pkg::FN_COMMON_TEST);
    // Subaddress is four bits, so every subaddress of functions 0 and 16 is legal
    assign valid = rd_thr | rd_mask | test_act | mod_reset | wr_thr | wr_mask | common_test;
endmodule : camac_func_decode
`default_nettype wire

// ===== verilog/comparator_sync.sv
// Two-stage synchroniser with rising-edge capture for one comparator line
`timescale 1ns/1ps
`default_nettype none
module comparator_sync #(
    parameter int STAGES = camac_disc_pkg::SYNC_STAGES
) (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic async_in,
    output logic      level,
    output logic      rise
);
    typedef struct packed {
        logic [STAGES-1:0] shift;
        logic              prev;
    } sync_state_t;

    sync_state_t state_ff;
    sync_state_t nxt_state;

    // Only the last stage is looked at, so metastability stays in the chain
    always_comb begin
        nxt_state       = state_ff;
        nxt_state.shift = {state_ff.shift[STAGES-2:0], async_in};
        nxt_state.prev  = state_ff.shift[STAGES-1];
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign level = state_ff.shift[STAGES-1];
    assign rise  = state_ff.shift[STAGES-1] & ~state_ff.prev;
endmodule : comparator_sync
`default_nettype wire
